// *** bench/sarcs_host_model.sv ***
// Host-side partner model: drives the convert strobe and picks up each result.
// Assumes one shared clock and a synchronous active-high reset.
`timescale 1ns/1ps
module sarcs_host_model
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        go,
    input  wire logic        result_valid,
    input  wire logic [15:0] result,
    output logic             convert_strobe,
    output logic [15:0]      read_value
);
    logic [1:0] hold; // Cycles left with the strobe held high.

    // ========================================================================
    // Strobe pulse
    // ========================================================================
    // A request raises the strobe for three cycles, so the device's
    // synchroniser cannot miss it; requests during a pulse are dropped.
    initial convert_strobe = 1'b0;
    always @(posedge clock)
    begin
        if (reset)
        begin
            hold           <= 2'h0;
            convert_strobe <= 1'b0;
        end
        else if (go && hold == 2'h0)
        begin
            hold           <= 2'h3;
            convert_strobe <= 1'b1;
        end
        else if (hold != 2'h0)
        begin
            hold           <= hold - 2'h1;
            convert_strobe <= (hold > 2'h1);
        end
    end

    // ========================================================================
    // Readback
    // ========================================================================
    // The host reads only once the conversion has ended, never earlier.
    always @(posedge clock)
    begin
        if (reset)
            read_value <= 16'h0000;
        else if (result_valid)
            read_value <= result;
    end
endmodule : sarcs_host_model

// *** bench/sarcs_sequencer_tb.sv ***
// Self-checking bench for the conversion sequencer with a host model.
// Assumes the design's own assertions are compiled with it.
`timescale 1ns/1ps
module sarcs_sequencer_tb;
    import sarcs_pkg::*;
    logic        clock, reset, go, comparator_high;
    logic        convert_strobe, pos_sw, neg_sw, to_inputs;
    logic        powered_up, busy, result_valid;
    logic [15:0] to_ref, result, read_value;
    int          vin;             // Sampled input in LSB, may lie out of range.
    int          mismatches = 0;  // Failed comparisons.
    int          n_tests = 0;     // All comparisons.
    int          rv_count = 0;    // Result pulses seen.
    int          cycles = 0;      // Cycles since start, for the hang limit.
    int          corners[6] = '{0, 1, 32768, 65535, 70000, -5};

    // ========================================================================
    // Clock, partner and design
    // ========================================================================
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    sarcs_host_model host (.clock(clock), .reset(reset), .go(go), .result_valid(result_valid),
        .result(result), .convert_strobe(convert_strobe), .read_value(read_value));
    // Short step and clamp counts keep the run brief.
    sarcs_sequencer #(.BITS(16), .STEP_CYC(2), .CLAMP_CYC(2)) dut (.clock(clock), .reset(reset),
        .convert_strobe(convert_strobe), .comparator_high(comparator_high),
        .pos_ground_clamp_switch(pos_sw), .neg_ground_clamp_switch(neg_sw),
        .array_to_inputs(to_inputs), .array_to_ref(to_ref), .powered_up(powered_up),
        .busy(busy), .result_valid(result_valid), .result(result));

    // Comparator model: high when the input is at or above the trial value.
    always @(posedge clock) #1 comparator_high = (int'(to_ref) <= vin);
    always @(posedge clock) if (!reset && result_valid === 1'b1) rv_count++;
    // Clamps must already be open whenever the arrays are off the inputs.
    always @(negedge clock) if (!reset && to_inputs === 1'b0) check("clamps", {pos_sw, neg_sw}, 0);
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    // ========================================================================
    // Helpers
    // ========================================================================
    // Ideal code: out-of-range inputs pin to the end codes.
    function automatic logic [15:0] exp_code(input int v);
        if (v < 0) return SARCS_CODE_ZERO;
        if (v > 65535) return SARCS_CODE_FULL;
        return v[15:0];
    endfunction : exp_code

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic kick();
        @(posedge clock);
        #1 go = 1'b1;
        @(posedge clock);
        #1 go = 1'b0;
    endtask : kick

    // Waits up to lim cycles for busy, or for result_valid when on_valid is set.
    task automatic wait_hi(input bit on_valid, input int lim);
        for (int k = 0; k < lim && (on_valid ? result_valid : busy) !== 1'b1; k++)
        begin
            @(posedge clock);
            #2;
        end
    endtask : wait_hi

    // One conversion; with again set a second strobe lands mid-conversion.
    task automatic convert(input int v, input bit again);
        vin = v;
        kick();
        wait_hi(1'b0, 20);
        check("busy", busy, 1);
        check("powered", powered_up, 1);
        if (again) kick();
        for (int k = 0; k < 20 && to_inputs !== 1'b0; k++) begin @(posedge clock); #2; end
        check("first trial", to_ref, SARCS_CODE_MID);
        // A third edge rises three cycles before busy falls and must be dropped too.
        if (again)
        begin
            repeat (29) @(posedge clock);
            kick();
        end
        wait_hi(1'b1, 300);
        check("result", result, exp_code(v));
        check("idle", {busy, powered_up, pos_sw, neg_sw, to_inputs, to_ref}, 21'h070000);
        @(posedge clock);
        #2 check("host copy", read_value, exp_code(v));
        if (again)
        begin
            repeat (10) @(posedge clock);
            #2 check("no relaunch", busy, 0);
        end
    endtask : convert

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial
    begin
        reset = 1'b1;
        go = 1'b0;
        vin = 0;
        comparator_high = 1'b0;
        void'($urandom(1805));
        repeat (2) @(posedge clock);
        #1 reset = 1'b0;
        check("reset state", {busy, powered_up, pos_sw, neg_sw, to_inputs, to_ref, result_valid, result},
              38'h0E00000000);
        // Corners: zero, one LSB, midscale, full scale, overrange, underrange.
        foreach (corners[i]) convert(corners[i], i == 2);
        // Random codes, each strobe raised three cycles after the previous busy falls.
        repeat (20) convert(int'($urandom_range(0, 65535)), 1'b0);
        check("result count", rv_count, 26);
        end_of_test();
    end
endmodule : sarcs_sequencer_tb

// *** rtl/sarcs_edge_sync.sv ***
// Two-stage synchroniser with rising-edge detect for the convert strobe pin.
// Assumes the pin is asynchronous to clock; the first stage feeds only the second.
`timescale 1ns/1ps
module sarcs_edge_sync
    import sarcs_pkg::*;
(
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic pin,
    output logic      rise
);

    // ========================================================================
    // Synchroniser stages
    // ========================================================================
    logic meta;       // First stage, read only by the second stage.
    logic sync;       // Second stage, safe to use.
    logic last;       // Previous synchronised value for edge detect.
    logic next_rise;  // Edge decision for the next cycle.

    // Edge is decided from the two safe stages only.
    always_comb
    begin
        next_rise = sync & ~last;
    end

    // Registers the stages and the edge pulse.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
            rise <= 1'b0;
        end
        else
        begin
            meta <= pin;
            sync <= meta;
            last <= sync;
            rise <= next_rise;
        end
    end

endmodule : sarcs_edge_sync

// *** rtl/sarcs_pkg.sv ***
// Package for the successive-approximation conversion sequencer.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package sarcs_pkg;

    // ========================================================================
    // Converter geometry
    // ========================================================================
    localparam int          SARCS_BITS       = 16;         // Result width, one array element per bit.
    localparam logic [15:0] SARCS_CODE_ZERO  = 16'h0000;   // Code for zero or underranged input.
    localparam logic [15:0] SARCS_CODE_MID   = 16'h8000;   // Midscale code, also the first trial value.
    localparam logic [15:0] SARCS_CODE_FULL  = 16'hFFFF;   // Code for full scale and overrange.

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int SARCS_CLK_PERIOD_NS  = 10;     // System clock period in ns.
    localparam int SARCS_CLAMP_OPEN_NS  = 20;     // Least time clamps stay open before arrays switch.
    localparam int SARCS_CLAMP_CYC      = (SARCS_CLAMP_OPEN_NS + SARCS_CLK_PERIOD_NS - 1) / SARCS_CLK_PERIOD_NS;
    localparam int SARCS_STEP_NS        = 40;     // Least settling time of one bit decision.
    localparam int SARCS_STEP_CYC       = (SARCS_STEP_NS + SARCS_CLK_PERIOD_NS - 1) / SARCS_CLK_PERIOD_NS;
    localparam int SARCS_RATE_FAST_KSPS = 500;    // Faster variant throughput.
    localparam int SARCS_RATE_SLOW_KSPS = 100;    // Slower variant throughput.
    localparam int SARCS_CNT_W          = 8;      // Width of the phase timer.
    localparam int SARCS_SYNC_DEPTH     = 3;      // Cycles from strobe pin edge to the edge pulse.

    // ========================================================================
    // Phases of a conversion
    // ========================================================================
    typedef enum logic [2:0]
    {
        SARCS_ACQUIRE,
        SARCS_OPEN_CLAMP,
        SARCS_HOLD,
        SARCS_RESOLVE,
        SARCS_FINISH
    } sarcs_phase_e;

endpackage : sarcs_pkg

// *** rtl/sarcs_sequencer.sv ***
// Conversion sequencer for a 16-bit charge-redistribution converter.
// Assumes the comparator output settles within one step time and the host paces starts.
`timescale 1ns/1ps
module sarcs_sequencer
    import sarcs_pkg::*;
#(
    parameter int BITS      = SARCS_BITS,        // Number of trial steps.
    parameter int STEP_CYC  = SARCS_STEP_CYC,    // Clock cycles per bit decision.
    parameter int CLAMP_CYC = SARCS_CLAMP_CYC    // Clock cycles with clamps open before switching.
)
(
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic              convert_strobe,
    input  wire logic              comparator_high,
    output logic                   pos_ground_clamp_switch,
    output logic                   neg_ground_clamp_switch,
    output logic                   array_to_inputs,
    output logic [BITS-1:0]        array_to_ref,
    output logic                   powered_up,
    output logic                   busy,
    output logic                   result_valid,
    output logic [BITS-1:0]        result
);

    // ========================================================================
    // Elaboration checks
    // ========================================================================
    // The timer is 8 bits wide and the code constants are 16 bits wide.
    if (BITS != SARCS_BITS || STEP_CYC < 1 || STEP_CYC > 255 || CLAMP_CYC < 1 || CLAMP_CYC > 255)
    begin : g_bad_param
        $error("sarcs_sequencer: unsupported parameter values");
    end

    // ========================================================================
    // Start detection
    // ========================================================================
    logic start_rise;  // One-cycle pulse on a synchronised strobe rising edge.

    // The strobe is a pin, so it passes three flip-flops before use.
    sarcs_edge_sync u_start_sync
    (
        .clock (clock),
        .reset (reset),
        .pin   (convert_strobe),
        .rise  (start_rise)
    );

    // ========================================================================
    // Sequencer state
    // ========================================================================
    sarcs_phase_e           phase;            // Current phase.
    sarcs_phase_e           next_phase;
    logic [SARCS_CNT_W-1:0] timer;            // Cycles left in the current phase step.
    logic [SARCS_CNT_W-1:0] next_timer;
    logic [4:0]             bit_idx;          // Bit under trial, counts down from MSB.
    logic [4:0]             next_bit_idx;
    logic [BITS-1:0]        trial;            // Array switch pattern, one bit per element.
    logic [BITS-1:0]        next_trial;
    logic [BITS-1:0]        next_result;
    logic                   next_valid;
    logic [1:0]             acq_age;          // Cycles spent in acquisition, saturating at GUARD.
    logic [1:0]             next_acq_age;

    // Phase timing loads, cut to the timer width on purpose.
    localparam logic [SARCS_CNT_W-1:0] CLAMP_LOAD = SARCS_CNT_W'(CLAMP_CYC - 1);
    localparam logic [SARCS_CNT_W-1:0] STEP_LOAD  = SARCS_CNT_W'(STEP_CYC - 1);
    localparam logic [4:0]             MSB_IDX    = 5'(BITS - 1);
    localparam logic [1:0]             GUARD      = 2'(SARCS_SYNC_DEPTH);

    // Next-state logic for the whole conversion. All timing comes from clock,
    // never from a serial shift clock, so readout cannot disturb a conversion.
    always_comb
    begin
        next_phase   = phase;
        next_timer   = timer;
        next_bit_idx = bit_idx;
        next_trial   = trial;
        next_result  = result;
        next_valid   = 1'b0;
        next_acq_age = acq_age;
        case (phase)
            SARCS_ACQUIRE:
            begin
                // Arrays track the inputs; the core is powered down.
                // An edge pulse within the synchroniser delay of the return rose while
                // busy, so it is dropped; an edge raised as busy falls is still taken,
                // which keeps back-to-back starts at the full rate.
                if (start_rise && acq_age == GUARD)
                begin
                    next_phase = SARCS_OPEN_CLAMP;
                    next_timer = CLAMP_LOAD;
                end
            end
            SARCS_OPEN_CLAMP:
            begin
                // Clamps open while arrays still hold the sample.
                if (timer == '0)
                begin
                    next_phase   = SARCS_HOLD;
                    next_timer   = STEP_LOAD;
                    next_bit_idx = MSB_IDX;
                    next_trial   = SARCS_CODE_MID;
                end
                else
                begin
                    next_timer = timer - 1'b1;
                end
            end
            SARCS_HOLD:
            begin
                // Arrays grounded, MSB element at reference, settling.
                next_phase = SARCS_RESOLVE;
            end
            SARCS_RESOLVE:
            begin
                // Decide one bit per step; keep it if comparator says input is above trial.
                if (timer == '0)
                begin
                    next_timer = STEP_LOAD;
                    if (!comparator_high)
                    begin
                        next_trial[bit_idx[3:0]] = 1'b0;
                    end
                    if (bit_idx == 5'h00)
                    begin
                        next_phase = SARCS_FINISH;
                    end
                    else
                    begin
                        next_bit_idx                     = bit_idx - 5'h01;
                        next_trial[bit_idx[3:0] - 4'h1]  = 1'b1;
                    end
                end
                else
                begin
                    next_timer = timer - 1'b1;
                end
            end
            SARCS_FINISH:
            begin
                // The trial pattern is the straight-binary code; an input above
                // reference keeps every bit (FFFF), one below ground drops every bit (0000).
                next_result = trial;
                next_valid  = 1'b1;
                next_trial  = SARCS_CODE_ZERO;
                next_phase  = SARCS_ACQUIRE;
            end
            default:
            begin
                next_phase = SARCS_ACQUIRE;
            end
        endcase
        // Strobe edges outside acquisition fall through untouched.
        // The age restarts on every conversion so late strobe edges are screened.
        if (phase != SARCS_ACQUIRE)
        begin
            next_acq_age = '0;
        end
        else if (acq_age != GUARD)
        begin
            next_acq_age = acq_age + 2'h1;
        end
    end

    // Registers the sequencer state.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            phase        <= SARCS_ACQUIRE;
            timer        <= '0;
            bit_idx      <= '0;
            trial        <= SARCS_CODE_ZERO;
            result       <= SARCS_CODE_ZERO;
            result_valid <= 1'b0;
            acq_age      <= GUARD;
        end
        else
        begin
            phase        <= next_phase;
            timer        <= next_timer;
            bit_idx      <= next_bit_idx;
            trial        <= next_trial;
            result       <= next_result;
            result_valid <= next_valid;
            acq_age      <= next_acq_age;
        end
    end

    // ========================================================================
    // Switch and power outputs
    // ========================================================================
    logic next_clamp;
    logic next_inputs;
    logic next_power;

    // Outputs are registered from the next phase, so they line up with phase.
    always_comb
    begin
        next_clamp  = (next_phase == SARCS_ACQUIRE);
        next_inputs = (next_phase == SARCS_ACQUIRE) || (next_phase == SARCS_OPEN_CLAMP);
        next_power  = (next_phase != SARCS_ACQUIRE);
    end

    // Registers switch drives; clamps closed and arrays on inputs at reset.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pos_ground_clamp_switch <= 1'b1;
            neg_ground_clamp_switch <= 1'b1;
            array_to_inputs         <= 1'b1;
            array_to_ref            <= SARCS_CODE_ZERO;
            powered_up              <= 1'b0;
            busy                    <= 1'b0;
        end
        else
        begin
            pos_ground_clamp_switch <= next_clamp;
            neg_ground_clamp_switch <= next_clamp;
            array_to_inputs         <= next_inputs;
            array_to_ref            <= next_trial;
            powered_up              <= next_power;
            busy                    <= next_power;
        end
    end

    // ========================================================================
    // Assertions
    // ========================================================================
    sequence s_start;
        phase == SARCS_ACQUIRE && start_rise && acq_age == GUARD;
    endsequence

    sequence s_clamps_open;
        !pos_ground_clamp_switch && !neg_ground_clamp_switch;
    endsequence

    AST_START: assert property (@(posedge clock) disable iff (reset)
        s_start |=> phase == SARCS_OPEN_CLAMP)
        else $error("start edge did not begin conversion");

    AST_CLAMP_ORDER: assert property (@(posedge clock) disable iff (reset)
        $fell(array_to_inputs) |-> s_clamps_open ##0 $past(!pos_ground_clamp_switch))
        else $error("arrays left inputs before clamps opened");

    AST_MSB_FIRST: assert property (@(posedge clock) disable iff (reset)
        phase == SARCS_HOLD |-> trial == SARCS_CODE_MID && bit_idx == MSB_IDX)
        else $error("first trial is not midscale");

    AST_DURATION: assert property (@(posedge clock) disable iff (reset)
        s_start |=> phase != SARCS_ACQUIRE [*8])
        else $error("conversion ended too early");

    AST_RETURN: assert property (@(posedge clock) disable iff (reset)
        phase == SARCS_FINISH |=> phase == SARCS_ACQUIRE ##1 pos_ground_clamp_switch)
        else $error("no return to acquisition");

    AST_RESULT: assert property (@(posedge clock) disable iff (reset)
        phase == SARCS_FINISH |=> result_valid && result == $past(trial))
        else $error("result not presented after conversion");

    AST_POWER: assert property (@(posedge clock) disable iff (reset)
        phase == SARCS_ACQUIRE && !$past(phase == SARCS_FINISH) |-> !powered_up)
        else $error("powered up between conversions");

    AST_OVERRANGE: assert property (@(posedge clock) disable iff (reset)
        phase == SARCS_RESOLVE && comparator_high && trial == SARCS_CODE_FULL && bit_idx == 5'h00
        && timer == '0 |=> ##1 result == SARCS_CODE_FULL)
        else $error("overrange did not saturate");

    AST_IGNORE: assert property (@(posedge clock) disable iff (reset)
        phase == SARCS_RESOLVE && start_rise |=> phase == SARCS_RESOLVE || phase == SARCS_FINISH)
        else $error("restart during conversion");

    AST_LATE_EDGE: assert property (@(posedge clock) disable iff (reset)
        phase == SARCS_ACQUIRE && start_rise && acq_age != GUARD |=> phase == SARCS_ACQUIRE)
        else $error("strobe edge from a busy period started a conversion");

endmodule : sarcs_sequencer
